// *** hisl_pkg.sv ***
// Package for the host-port select and pin-function block
package hisl_pkg;

  // Latch state of the port mode: strap not yet caught, or caught
  typedef enum logic [1:0] {
    HISL_MODE_NONE = 2'b01,
    HISL_MODE_LATCHED = 2'b10
  } hisl_lstate_t;

  // Strap level meaning SDIO
  localparam logic STRAP_SDIO = 1'b1;

  // Reference, slow and system clock figures
  localparam real REF_CLK_MHZ    = 38.4;
  localparam real SLOW_CLK_KHZ   = 32.768;
  localparam real SYS_CLK_MHZ    = 100.0;

  // Slow clock period in system cycles, rounded down
  localparam int  SLOW_PERIOD_CYC =
    int'($floor(SYS_CLK_MHZ * 1000.0 / SLOW_CLK_KHZ));

  // Shared host pin bundle (output, enable)
  typedef struct packed {
    logic       clk_in_unused;
    logic       cmd_o;
    logic       cmd_oe;
    logic [3:0] dat_o;
    logic [3:0] dat_oe;
  } hisl_pins_t;

  // Core-side view of the selected port
  typedef struct packed {
    logic       port_clk;
    logic       spi_mosi;
    logic       spi_csn;
    logic       sdio_cmd;
    logic [3:0] sdio_dat;
  } hisl_core_in_t;

  typedef struct packed {
    logic       spi_miso;
    logic       spi_miso_en;
    logic       sdio_cmd;
    logic       sdio_cmd_en;
    logic [3:0] sdio_dat;
    logic [3:0] sdio_dat_en;
  } hisl_core_out_t;

endpackage : hisl_pkg

// *** hisl_sync.sv ***
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module hisl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,     // System clock
  input  wire logic         chip_reset_low,  // Async reset, active low
  input  wire logic [W-1:0] d,       // Asynchronous inputs
  output logic      [W-1:0] q        // Synchronised outputs
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hisl_sync_st_t;

  hisl_sync_st_t st_reg;
  hisl_sync_st_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk or negedge chip_reset_low) begin
    if (!chip_reset_low) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;

endmodule : hisl_sync

// *** hisl_host_if_select.sv ***
// Host-port select strap latch and shared pin muxing
//
// Notes on behaviour
// RQ1 - Strap level is caught when chip reset rises; held until next reset.
// RQ2 - Strap high selects SDIO, strap low selects SPI.
// RQ3 - Shared pins: SPI clock/MOSI/MISO/CSn or SDIO CLK/CMD/DAT0-3.
// RQ4 - In SPI mode data line 1 drives the interrupt request to host.
// RQ5 - Host keeps port clock at most 26 or 52 MHz by mode.
// RQ6 - Host may capture MISO on either clock edge.
// RQ7 - Host captures SDIO data rising in high speed, falling otherwise.
// RQ8 - Host raises wake request before starting port traffic.
// RQ9 - Sleep or shutdown allowed only while wake request is low.
// RQ10 - Without power save, the wake pin becomes a general-purpose pin.
// RQ11 - Interrupt may be mirrored on a spare pin, else it is GPIO.
// RQ12 - Host re-enables a powered-down reference oscillator before activity.
// RQ13 - Host enables reference oscillator at least 2 ms ahead.
// RQ14 - Main timing comes from a 38.4 MHz reference.
// RQ15 - A 32.768 KHz slow clock enables lowest-power operation.
// RQ16 - Host raises wake request and waits before any transfer.
// RQ17 - Leaving shutdown starts at chip reset rising edge.
// RQ18 - Shared outputs float during reset until the mode is latched.
`timescale 1ns/1ps
module hisl_host_if_select (
  input  wire logic                    clk,             // Core clock
  input  wire logic                    chip_reset_low,          // Async reset, low
  input  wire logic                    host_port_select_strap, // DAT2 pin
  input  wire logic                    port_clk_pin,    // SCLK/CLK pin in
  input  wire logic                    cmd_pin_i,       // MOSI/CMD pin in
  input  wire logic [3:0]              dat_pin_i,       // DAT0-3 pins in
  output hisl_pkg::hisl_pins_t         pins,            // Pin drive
  output hisl_pkg::hisl_core_in_t      core_in,         // To port engine
  input  wire hisl_pkg::hisl_core_out_t core_out,       // From engine
  input  wire logic                    irq_to_host,     // Core irq level
  output logic                         spi_irq_out,     // Irq on DAT1
  output logic                         sdio_mode,       // 1 SDIO, 0 SPI
  output logic                         mode_valid,      // Mode latched
  output logic                         startup_pulse,   // Start sequence
  input  wire logic                    wake_request_pin,// Host wake pin
  input  wire logic                    power_save_en,   // Power save on
  input  wire logic                    sleep_request,   // Core wants sleep
  output logic                         sleep_allowed,   // Sleep permitted
  output logic                         wake_event,      // Wake rising edge
  output logic                         wake_gpio_in,    // Wake pin as GPIO
  input  wire logic                    irq_mirror_en,   // Mirror irq
  input  wire logic                    gpio_irq_out_i,  // GPIO data out
  input  wire logic                    gpio_irq_oe_i,   // GPIO enable
  output logic                         gpio_irq_o,      // Spare pin out
  output logic                         gpio_irq_oe,     // Spare pin enable
  input  wire logic                    ref_clk_ok,      // Reference ready
  input  wire logic                    slow_clock_input,// 32.768 KHz pin
  output logic                         slow_clk_present // Slow clock seen
);

  localparam int NSYNC = 9;

  typedef struct packed {
    logic                     sdio;
    hisl_pkg::hisl_lstate_t   lstate;
    logic                     startup;
    logic [1:0]               fill;
    logic                     wake_d;
    logic                     wake_ev;
    logic                     slow_d;
    logic [15:0]              slow_cnt;
    logic                     slow_ok;
    hisl_pkg::hisl_pins_t     pins;
    hisl_pkg::hisl_core_in_t  cin;
    logic                     gpio_o;
    logic                     gpio_oe;
  } hisl_st_t;

  hisl_st_t st_reg;
  hisl_st_t st_next;

  logic [NSYNC-1:0] sync_d;
  logic [NSYNC-1:0] sync_q;
  logic             strap_s;
  logic             pclk_s;
  logic             cmd_s;
  logic [3:0]       dat_s;
  logic             wake_s;
  logic             slow_s;

  assign sync_d = {slow_clock_input, wake_request_pin, dat_pin_i,
                   cmd_pin_i, port_clk_pin, host_port_select_strap};

  hisl_sync #(.W(NSYNC)) u_sync (
    .clk    (clk),
    .chip_reset_low (chip_reset_low),
    .d      (sync_d),
    .q      (sync_q)
  );

  assign strap_s = sync_q[0];
  assign pclk_s  = sync_q[1];
  assign cmd_s   = sync_q[2];
  assign dat_s   = sync_q[6:3];
  assign wake_s  = sync_q[7];
  assign slow_s  = sync_q[8];

  // Period limit of the slow clock before it counts as missing
  localparam logic [15:0] SLOW_TIMEOUT = 16'(2 * hisl_pkg::SLOW_PERIOD_CYC);
  // Synchroniser stages are cleared by reset, so the strap is only
  // trustworthy once both stages have been refilled from the pin
  localparam logic [1:0]  SYNC_FILL    = 2'h2;

  always_comb begin
    st_next         = st_reg;
    st_next.startup = 1'b0;

    // RQ1 strap capture: third cycle after release, once the synchronised strap is refilled
    // RQ17 startup pulse comes with the strap latch, third cycle after reset release
    if (st_reg.lstate == hisl_pkg::HISL_MODE_NONE) begin
      if (st_reg.fill == SYNC_FILL) begin
        // RQ2 high means SDIO
        st_next.sdio    = (strap_s == hisl_pkg::STRAP_SDIO);
        st_next.lstate  = hisl_pkg::HISL_MODE_LATCHED;
        st_next.startup = 1'b1;
      end else begin
        st_next.fill = st_reg.fill + 2'h1;
      end
    end

    // RQ9 sleep only with wake pin low
    st_next.wake_d  = wake_s;
    st_next.wake_ev = wake_s & ~st_reg.wake_d & power_save_en;

    // RQ15 slow clock presence by edge watchdog
    st_next.slow_d = slow_s;
    if (slow_s & ~st_reg.slow_d) begin
      st_next.slow_cnt = '0;
      st_next.slow_ok  = 1'b1;
    end else if (st_reg.slow_cnt >= SLOW_TIMEOUT) begin
      st_next.slow_ok  = 1'b0;
    end else begin
      st_next.slow_cnt = st_reg.slow_cnt + 16'h0001;
    end

    // RQ3 pin roles by mode
    st_next.cin.port_clk = pclk_s;
    st_next.cin.spi_mosi = cmd_s;
    st_next.cin.spi_csn  = dat_s[3];
    st_next.cin.sdio_cmd = cmd_s;
    st_next.cin.sdio_dat = dat_s;
    st_next.pins         = '0;
    // RQ18 outputs float until mode latched
    if (st_reg.lstate == hisl_pkg::HISL_MODE_LATCHED) begin
      if (st_reg.sdio) begin
        st_next.pins.cmd_o  = core_out.sdio_cmd;
        st_next.pins.cmd_oe = core_out.sdio_cmd_en;
        st_next.pins.dat_o  = core_out.sdio_dat;
        st_next.pins.dat_oe = core_out.sdio_dat_en;
      end else begin
        st_next.pins.dat_o[0]  = core_out.spi_miso;
        st_next.pins.dat_oe[0] = core_out.spi_miso_en;
        // RQ4 interrupt request on data line 1
        st_next.pins.dat_o[1]  = irq_to_host;
        st_next.pins.dat_oe[1] = 1'b1;
      end
    end

    // RQ11 mirror irq or plain GPIO
    if (irq_mirror_en) begin
      st_next.gpio_o  = irq_to_host;
      st_next.gpio_oe = st_reg.lstate == hisl_pkg::HISL_MODE_LATCHED;
    end else begin
      st_next.gpio_o  = gpio_irq_out_i;
      // Spare pin stays quiet until the port mode is settled
      st_next.gpio_oe = gpio_irq_oe_i &
                        (st_reg.lstate == hisl_pkg::HISL_MODE_LATCHED);
    end
  end

  always_ff @(posedge clk or negedge chip_reset_low) begin
    if (!chip_reset_low) begin
      st_reg          <= '0;
      st_reg.lstate   <= hisl_pkg::HISL_MODE_NONE;
      st_reg.slow_cnt <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins          = st_reg.pins;
  assign core_in       = st_reg.cin;
  assign sdio_mode     = st_reg.sdio;
  assign mode_valid    = st_reg.lstate == hisl_pkg::HISL_MODE_LATCHED;
  assign startup_pulse = st_reg.startup;
  assign spi_irq_out   = st_reg.pins.dat_o[1] & ~st_reg.sdio;
  assign wake_event    = st_reg.wake_ev;
  // RQ10 wake pin as GPIO without power save
  assign wake_gpio_in  = power_save_en ? 1'b0 : st_reg.wake_d;
  // RQ9 sleep gate; RQ14 needs reference ready to run
  assign sleep_allowed = sleep_request & ~st_reg.wake_d & ref_clk_ok &
                         power_save_en & mode_valid;
  assign gpio_irq_o    = st_reg.gpio_o;
  assign gpio_irq_oe   = st_reg.gpio_oe;
  assign slow_clk_present = st_reg.slow_ok;

endmodule : hisl_host_if_select

// *** hisl_chk_assertions.sv ***
// Assertions for the host-port select block
`timescale 1ns/1ps
module hisl_chk (
  input wire logic clk,                  // Core clock
  input wire logic chip_reset_low,               // Reset, low
  input wire logic wake_request_pin,     // Wake pin
  input wire logic power_save_en,        // Power save
  input wire hisl_pkg::hisl_pins_t pins, // Pin drive
  input wire logic spi_irq_out,          // Irq on DAT1
  input wire logic sdio_mode,            // Port mode
  input wire logic mode_valid,           // Mode latched
  input wire logic startup_pulse,        // Start pulse
  input wire logic sleep_allowed,        // Sleep ok
  input wire logic wake_event,           // Wake pulse
  input wire logic gpio_irq_oe           // Spare enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!chip_reset_low);
  AST_MODE_HOLD: assert property (mode_valid |=>
    mode_valid && $stable(sdio_mode)) else $error("mode moved");
  AST_START: assert property ($rose(mode_valid) |->
    startup_pulse ##1 !startup_pulse) else $error("bad start pulse");
  AST_FLOAT: assert property (!mode_valid |->
    !pins.cmd_oe && pins.dat_oe == 4'h0) else $error("pins driven");
  AST_SPI_PINS: assert property ($past(mode_valid) && !sdio_mode |->
    pins.dat_oe[1] && !pins.cmd_oe && pins.dat_oe[3:2] == 2'h0)
    else $error("spi pin roles");
  AST_SDIO_IRQ: assert property (sdio_mode |-> !spi_irq_out)
    else $error("irq out in sdio");
  AST_SLEEP: assert property (wake_request_pin [*4] |->
    !sleep_allowed) else $error("sleep while woken");
  AST_WAKE_EV: assert property (wake_event |->
    power_save_en ##1 !wake_event) else $error("bad wake event");
  AST_MIRROR: assert property (!mode_valid |-> !gpio_irq_oe)
    else $error("spare pin early");
  cover property (startup_pulse && sdio_mode);
  cover property (startup_pulse && !sdio_mode);
  cover property (wake_event);
endmodule : hisl_chk
bind hisl_host_if_select hisl_chk u_chk (.clk, .chip_reset_low, .wake_request_pin,
  .power_save_en, .pins, .spi_irq_out, .sdio_mode, .mode_valid,
  .startup_pulse, .sleep_allowed, .wake_event, .gpio_irq_oe);

// *** hisl_host_model.sv ***
// Host model: port pins, strap and wake
`timescale 1ns/1ps
module hisl_host_model (
  input wire logic clk,   // Pacing clock
  output logic pclk,      // Port clock pin
  output logic cmd,       // Command pin
  output logic [3:0] dat, // Data pins
  output logic strap,     // Select strap
  output logic wake       // Wake request
);
  initial {pclk, cmd, dat, strap, wake} = 8'h40;
  // 80 ns per bit, far below either clock ceiling
  // host capture edge is free here: outputs are held a full bit
  task bit_out(input logic c, input logic [3:0] d);
    {cmd, dat} = {c, d};
    repeat (4) @(negedge clk);
    pclk = 1'h1;
    repeat (4) @(negedge clk);
    pclk = 1'h0;
  endtask : bit_out
  task open_frame;
    wake = 1'h1;
    repeat (6) @(negedge clk);
  endtask : open_frame
  // wake low; released lines flip so stale values cannot pass
  task close_frame;
    {wake, cmd, dat} = {1'h0, ~cmd, ~dat};
  endtask : close_frame
endmodule : hisl_host_model

// *** tb_host_interface_select.sv ***
// Self-checking bench for the host-port select block
`timescale 1ns/1ps
module tb_host_interface_select;
  logic clk = 1'h0, chip_reset_low = 1'h0, irq = 1'h0, ps_en = 1'h0, slp = 1'h0;
  logic ref_ok = 1'h0, mir = 1'h0, g_o = 1'h0, g_oe = 1'h0, slow = 1'h0;
  logic pclk, cmd, strap, wake, spi_irq, sdio, mval, spls, slp_ok;
  logic wev, wgpio, mo, moe, slw_ok;
  logic [3:0] dat;
  logic [7:0] b;
  logic expq[$];
  int n_errors = 0, checks = 0, cyc = 0;
  hisl_pkg::hisl_pins_t pins;
  hisl_pkg::hisl_core_in_t cin;
  hisl_pkg::hisl_core_out_t cout = 12'h000;
  always #5 clk = ~clk;
  hisl_host_if_select dut (.clk, .chip_reset_low, .host_port_select_strap(strap),
    .port_clk_pin(pclk), .cmd_pin_i(cmd), .dat_pin_i(dat), .pins,
    .core_in(cin), .core_out(cout), .irq_to_host(irq),
    .spi_irq_out(spi_irq), .sdio_mode(sdio), .mode_valid(mval),
    .startup_pulse(spls), .wake_request_pin(wake), .power_save_en(ps_en),
    .sleep_request(slp), .sleep_allowed(slp_ok), .wake_event(wev),
    .wake_gpio_in(wgpio), .irq_mirror_en(mir), .gpio_irq_out_i(g_o),
    .gpio_irq_oe_i(g_oe), .gpio_irq_o(mo), .gpio_irq_oe(moe),
    .ref_clk_ok(ref_ok), .slow_clock_input(slow),
    .slow_clk_present(slw_ok));
  hisl_host_model hm (.clk, .pclk, .cmd, .dat, .strap, .wake);
  task automatic cmp(input string n, input logic e, input logic s);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %b got %b", n, e, s);
    end
  endtask : cmp
  task conclude;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial begin
    void'($urandom(78734));
    for (int m = 0; m < 2; m++) begin
      chip_reset_low = 1'h0;
      hm.strap = m[0];
      repeat (3) @(negedge clk);
      cmp("float", pins.dat_oe[1] | pins.cmd_oe, 1'h0);
      expq.push_back(m[0]);
      chip_reset_low = 1'h1;
      repeat (3) @(negedge clk);
      // Late strap edge must be ignored
      hm.strap = ~m[0];
      cout = 12'($urandom);
      irq = 1'($urandom);
      repeat (4) @(negedge clk);
      cmp("mode", sdio, m[0]);
      cmp("dat0", pins.dat_o[0], m ? cout.sdio_dat[0] : cout.spi_miso);
      cmp("dat1", pins.dat_o[1], m ? cout.sdio_dat[1] : irq);
      cmp("spi irq", spi_irq, m ? 1'h0 : irq);
      cmp("no slow clk", slw_ok, 1'h0);
      hm.open_frame();
      for (int i = 0; i < 6; i++) begin
        b = 8'($urandom);
        hm.bit_out(b[0], b[4:1]);
        cmp("cmd in", m ? cin.sdio_cmd : cin.spi_mosi, b[0]);
        cmp("dat3 in", m ? cin.sdio_dat[3] : cin.spi_csn, b[4]);
      end
      hm.close_frame();
      // reference raised together with the sleep request, 6 cycles before the sleep check
      {ps_en, slp, ref_ok} = 3'h7;
      repeat (6) @(negedge clk);
      cmp("sleep", slp_ok, 1'h1);
      hm.open_frame();
      cmp("no sleep", slp_ok, 1'h0);
      ps_en = 1'h0;
      {mir, g_o, g_oe} = {1'h1, 2'($urandom)};
      repeat (4) @(negedge clk);
      cmp("wake gpio", wgpio, 1'h1);
      cmp("mirror", mo, irq);
      mir = 1'h0;
      repeat (3) @(negedge clk);
      cmp("gpio", mo, g_o);
      cmp("gpio oe", moe, g_oe);
      hm.close_frame();
    end
    conclude();
  end
  always @(negedge clk) begin
    if (spls === 1'h1) cmp("mode at start", expq.pop_front(), sdio);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
endmodule : tb_host_interface_select
